// ===== hw/mad_port.sv
// Dual-function port B, port C and strobe pin logic with AHB-Lite regs
//
// The address map and the AHB-Lite slave port were decided locally.
`timescale 1ns/100ps

// What this block does
// - Expanded mode turns 18 pins into bus
// - Single-chip: port B is output only
// - Single-chip: port C bits individually directed
// - Input strobe edge latches port C pins
// - Software selects the active strobe edge
// - Port C static I/O during latching
// - Strobe raises interrupt, level unreadable
// - Output strobe pin is software output
// - Low address byte in first half
// - Data byte bidirectional in second half
// - Address strobe high passes latch address
// - Read/write line high read, low write
// - Bus addresses 64 Kbyte space
// - Strobe pin output expanded, input single-chip
module mad_port (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Port B pins, output only
  output logic      [7:0]  output_port_bit,
  // Port C pins, two-way
  input  wire logic [7:0]  bidir_port_bit_in,
  output logic      [7:0]  bidir_port_bit_out,
  output logic      [7:0]  bidir_port_bit_oe,
  // Shared input strobe and address strobe pin
  input  wire logic        input_strobe_pin_in,
  output logic             address_latch_strobe_out,
  output logic             address_latch_strobe_oe,
  // Shared output strobe and read/write pin
  output logic             output_strobe_pin,
  // Bus clock and interrupt
  output logic             e_clk,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [2:0]  ctrl_reg;
  logic [7:0]  portb_reg;
  logic [7:0]  portc_reg;
  logic [7:0]  dirc_reg;
  logic [7:0]  latch_reg;
  logic [1:0]  stat_reg, stat_next;
  logic [1:0]  mask_reg;
  logic [15:0] xaddr_reg;
  logic [7:0]  xdata_reg;
  logic        xrd_reg;
  logic        start_reg;
  logic        output_strobe_pin_prev_reg;
  logic        wr_pend_reg;
  logic        rd_pend_reg;
  logic [7:0]  wr_off_reg;
  logic [7:0]  rd_off_reg;
  logic [31:0] hrdata_reg;
  logic [7:0]  pin_b_reg;
  logic [7:0]  pin_c_reg;
  logic [7:0]  pin_c_oe_reg;
  logic        pin_as_reg;
  logic        pin_as_oe_reg;
  logic        pin_output_strobe_pin_reg;
  logic        e_clk_reg;
  logic        irq_reg;
  logic [7:0]  pin_c_sync;
  logic        strobe_sync;

  mad_cyc_if cyc ();

  // Offset match, used by every register decode
  function automatic logic hit(input logic [7:0] off,
                               input logic [7:0] ref_off);
    hit = (off == ref_off);
  endfunction : hit

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  mad_sync2 #(
    .W (8)
  ) u_sync_c (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (bidir_port_bit_in),
    .q     (pin_c_sync)
  );

  mad_sync2 #(
    .W (1)
  ) u_sync_output_strobe_pin (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (input_strobe_pin_in),
    .q     (strobe_sync)
  );

  // ----------------------------------------------------------------
  // Expanded bus cycle sequencer
  // ----------------------------------------------------------------
  mad_ecycle u_cycle (
    .clk   (clk),
    .rst_n (rst_n),
    .cyc   (cyc.seq)
  );

  assign cyc.start = start_reg;
  assign cyc.rd    = xrd_reg;
  assign cyc.addr  = xaddr_reg;
  assign cyc.wdata = xdata_reg;
  assign cyc.pin_c = pin_c_sync;

  // ----------------------------------------------------------------
  // Mode and control decode
  // ----------------------------------------------------------------
  wire expanded = ctrl_reg[mad_pkg::CTRL_EXP_BIT];
  wire rise_pol = ctrl_reg[mad_pkg::CTRL_POL_BIT];
  wire output_strobe_pin_gp  = ctrl_reg[mad_pkg::CTRL_OUTPUT_STROBE_PIN_BIT];

  // Strobe edge of the selected polarity, single-chip only
  wire output_strobe_pin_rise  = strobe_sync && !output_strobe_pin_prev_reg;
  wire output_strobe_pin_fall  = !strobe_sync && output_strobe_pin_prev_reg;
  wire output_strobe_pin_edge  = !expanded
                    && (rise_pol ? output_strobe_pin_rise : output_strobe_pin_fall);

  // ----------------------------------------------------------------
  // AHB-Lite address phase and write decode
  // ----------------------------------------------------------------
  wire addr_ph = hsel && htrans[1] && hready;
  wire wr_ctrl = wr_pend_reg && hit(wr_off_reg, mad_pkg::OFF_CTRL);
  wire wr_pb   = wr_pend_reg && hit(wr_off_reg, mad_pkg::OFF_PORTB);
  wire wr_pc   = wr_pend_reg && hit(wr_off_reg, mad_pkg::OFF_PORTC);
  wire wr_dir  = wr_pend_reg && hit(wr_off_reg, mad_pkg::OFF_DIRC);
  wire wr_st   = wr_pend_reg && hit(wr_off_reg, mad_pkg::OFF_STATUS);
  wire wr_mask = wr_pend_reg && hit(wr_off_reg, mad_pkg::OFF_MASK);
  wire wr_xa   = wr_pend_reg && hit(wr_off_reg, mad_pkg::OFF_XADDR);
  wire wr_xd   = wr_pend_reg && hit(wr_off_reg, mad_pkg::OFF_XDATA);
  wire wr_xcmd = wr_pend_reg && hit(wr_off_reg, mad_pkg::OFF_XCMD);

  // Bus cycle starts only when expanded and idle
  wire go_cycle = wr_xcmd && expanded && !cyc.busy && !start_reg;

  // Status: hardware set wins over write-one clear
  wire [1:0] stat_set = {cyc.done, output_strobe_pin_edge};
  wire [1:0] stat_clr = wr_st ? hwdata[1:0] : 2'b00;
  assign stat_next = (stat_reg & ~stat_clr) | stat_set;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Port C reads: output bits give the data reg, inputs the pins
  wire [7:0] portc_rd = (portc_reg & dirc_reg)
                        | (pin_c_sync & ~dirc_reg);
  wire [2:0] stat_rd  = {cyc.busy, stat_reg};

  // Strobe pin level is deliberately absent from every read
  wire [31:0] rd_mux =
      hit(rd_off_reg, mad_pkg::OFF_CTRL)   ? {29'h0, ctrl_reg}  :
      hit(rd_off_reg, mad_pkg::OFF_PORTB)  ? {24'h0, portb_reg} :
      hit(rd_off_reg, mad_pkg::OFF_PORTC)  ? {24'h0, portc_rd}  :
      hit(rd_off_reg, mad_pkg::OFF_DIRC)   ? {24'h0, dirc_reg}  :
      hit(rd_off_reg, mad_pkg::OFF_LATCH)  ? {24'h0, latch_reg} :
      hit(rd_off_reg, mad_pkg::OFF_STATUS) ? {29'h0, stat_rd}   :
      hit(rd_off_reg, mad_pkg::OFF_MASK)   ? {30'h0, mask_reg}  :
      hit(rd_off_reg, mad_pkg::OFF_XADDR)  ? {16'h0, xaddr_reg} :
      hit(rd_off_reg, mad_pkg::OFF_XDATA)  ? {24'h0, xdata_reg} :
      32'h0000_0000;

  // ----------------------------------------------------------------
  // Bus slave pipeline
  // ----------------------------------------------------------------
  // One wait state on reads, none on writes
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      wr_off_reg  <= 8'h00;
      rd_off_reg  <= 8'h00;
      hrdata_reg  <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_reg <= addr_ph && hwrite;
      rd_pend_reg <= addr_ph && !hwrite;
      if (addr_ph)
      begin
        wr_off_reg <= haddr[7:0];
        rd_off_reg <= haddr[7:0];
      end
      if (rd_pend_reg)
        hrdata_reg <= rd_mux;
    end
  end

  assign hreadyout = !rd_pend_reg;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  // ----------------------------------------------------------------
  // Control and port registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl_reg  <= mad_pkg::RST_CTRL;
      portb_reg <= mad_pkg::RST_BYTE;
      portc_reg <= mad_pkg::RST_BYTE;
      dirc_reg  <= mad_pkg::RST_BYTE;
      mask_reg  <= 2'b00;
      stat_reg  <= 2'b00;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= hwdata[2:0];
      if (wr_pb)
        portb_reg <= hwdata[7:0];
      if (wr_pc)
        portc_reg <= hwdata[7:0];
      if (wr_dir)
        dirc_reg <= hwdata[7:0];
      if (wr_mask)
        mask_reg <= hwdata[1:0];
      stat_reg <= stat_next;
    end
  end

  // ----------------------------------------------------------------
  // Strobe edge capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      output_strobe_pin_prev_reg <= 1'b0;
      latch_reg     <= mad_pkg::RST_BYTE;
    end
    else
    begin
      output_strobe_pin_prev_reg <= strobe_sync;
      if (output_strobe_pin_edge)
        latch_reg <= pin_c_sync;
    end
  end

  // ----------------------------------------------------------------
  // Expanded bus request registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      xaddr_reg <= 16'h0000;
      xdata_reg <= mad_pkg::RST_BYTE;
      xrd_reg   <= 1'b1;
      start_reg <= 1'b0;
    end
    else
    begin
      start_reg <= go_cycle;
      if (wr_xa && !cyc.busy)
        xaddr_reg <= hwdata[15:0];
      if (wr_xd && !cyc.busy)
        xdata_reg <= hwdata[7:0];
      else if (cyc.done && xrd_reg)
        xdata_reg <= cyc.rdata;
      if (go_cycle)
        xrd_reg <= hwdata[mad_pkg::XCMD_RD_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Pin output selection
  // ----------------------------------------------------------------
  // Drive the data byte only for write data halves
  wire       c_drv_data = cyc.data_ph && !xrd_reg;
  wire       c_drv_addr = cyc.busy && !cyc.data_ph;
  wire [7:0] c_out_exp  = c_drv_addr ? xaddr_reg[7:0]
                                     : xdata_reg;
  wire [7:0] c_oe_exp   = (c_drv_addr || c_drv_data) ? 8'hff : 8'h00;
  wire [7:0] b_next     = expanded ? xaddr_reg[15:8]
                                   : portb_reg;
  wire [7:0] c_next     = expanded ? c_out_exp : portc_reg;
  wire [7:0] c_oe_next  = expanded ? c_oe_exp : dirc_reg;
  wire       output_strobe_pin_next  = expanded ? xrd_reg
                                   : output_strobe_pin_gp;

  // Registered pin drivers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pin_b_reg     <= mad_pkg::RST_BYTE;
      pin_c_reg     <= mad_pkg::RST_BYTE;
      pin_c_oe_reg  <= 8'h00;
      pin_as_reg    <= 1'b0;
      pin_as_oe_reg <= 1'b0;
      pin_output_strobe_pin_reg  <= 1'b0;
      e_clk_reg     <= 1'b0;
      irq_reg       <= 1'b0;
    end
    else
    begin
      pin_b_reg     <= b_next;
      pin_c_reg     <= c_next;
      pin_c_oe_reg  <= c_oe_next;
      pin_as_reg    <= expanded && cyc.as_hi;
      pin_as_oe_reg <= expanded;
      pin_output_strobe_pin_reg  <= output_strobe_pin_next;
      e_clk_reg     <= expanded && cyc.e_clk;
      irq_reg       <= |(stat_next & mask_reg);
    end
  end

  assign output_port_bit          = pin_b_reg;
  assign bidir_port_bit_out       = pin_c_reg;
  assign bidir_port_bit_oe        = pin_c_oe_reg;
  assign address_latch_strobe_out = pin_as_reg;
  assign address_latch_strobe_oe  = pin_as_oe_reg;
  assign output_strobe_pin        = pin_output_strobe_pin_reg;
  assign e_clk                    = e_clk_reg;
  assign irq                      = irq_reg;

endmodule : mad_port

// ===== pkg/mad_pkg.sv
// Constants and types shared by the multiplexed address/data port
package mad_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS      = 20;
  localparam int E_HALF_NS   = 250;
  localparam int AS_HIGH_NS  = 100;
  // Half bus cycle, longest time rounds down
  localparam int E_HALF_CYC  = (E_HALF_NS / CLK_NS < 1) ? 1
                               : E_HALF_NS / CLK_NS;
  // Strobe high time, least time rounds up
  localparam int AS_HIGH_CYC = (AS_HIGH_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int PORT_W = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_PORTB  = 8'h04;
  localparam logic [7:0] OFF_PORTC  = 8'h08;
  localparam logic [7:0] OFF_DIRC   = 8'h0c;
  localparam logic [7:0] OFF_LATCH  = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_MASK   = 8'h18;
  localparam logic [7:0] OFF_XADDR  = 8'h1c;
  localparam logic [7:0] OFF_XDATA  = 8'h20;
  localparam logic [7:0] OFF_XCMD   = 8'h24;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_EXP_BIT  = 0;
  localparam int CTRL_POL_BIT  = 1;
  localparam int CTRL_OUTPUT_STROBE_PIN_BIT = 2;
  localparam int ST_EDGE_BIT   = 0;
  localparam int ST_DONE_BIT   = 1;
  localparam int ST_BUSY_BIT   = 2;
  localparam int XCMD_RD_BIT   = 0;
  localparam logic [2:0] RST_CTRL = 3'h0;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Expanded bus cycle phases
  typedef enum logic [1:0] {
    CYC_IDLE = 2'b00,
    CYC_ADDR = 2'b01,
    CYC_DATA = 2'b10
  } mad_cyc_state_t;

endpackage : mad_pkg

// ===== pkg/mad_cyc_if.sv
// Request and status signals of one expanded bus cycle
`timescale 1ns/100ps
interface mad_cyc_if;
  logic        start;
  logic        rd;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [7:0]  pin_c;
  logic        busy;
  logic        done;
  logic        e_clk;
  logic        as_hi;
  logic        data_ph;

  modport ctl (output start, rd, addr, wdata, pin_c,
               input rdata, busy, done, e_clk, as_hi, data_ph);
  modport seq (input start, rd, addr, wdata, pin_c,
               output rdata, busy, done, e_clk, as_hi, data_ph);
endinterface : mad_cyc_if

// ===== hw/mad_sync2.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module mad_sync2 #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : mad_sync2

// ===== hw/mad_ecycle.sv
// Sequencer for one expanded multiplexed bus cycle
`timescale 1ns/100ps
module mad_ecycle (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Cycle request and status
  mad_cyc_if.seq    cyc
);

  mad_pkg::mad_cyc_state_t state_reg, state_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [7:0] rdata_reg;
  logic       done_reg;

  localparam logic [7:0] HALF_LAST = 8'(mad_pkg::E_HALF_CYC - 1);
  localparam logic [7:0] AS_CNT    = 8'(mad_pkg::AS_HIGH_CYC);

  wire half_end = (cnt_reg == HALF_LAST);

  // Phase sequencing: address half, then data half
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg + 8'h01;
    case (state_reg)
      mad_pkg::CYC_IDLE:
      begin
        cnt_next = 8'h00;
        if (cyc.start)
          state_next = mad_pkg::CYC_ADDR;
      end
      mad_pkg::CYC_ADDR:
        if (half_end)
        begin
          state_next = mad_pkg::CYC_DATA;
          cnt_next   = 8'h00;
        end
      mad_pkg::CYC_DATA:
        if (half_end)
        begin
          state_next = mad_pkg::CYC_IDLE;
          cnt_next   = 8'h00;
        end
      default:
      begin
        state_next = mad_pkg::CYC_IDLE;
        cnt_next   = 8'h00;
      end
    endcase
  end

  wire last_data = (state_reg == mad_pkg::CYC_DATA) && half_end;

  // State, read capture at end of the data half
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= mad_pkg::CYC_IDLE;
      cnt_reg   <= 8'h00;
      rdata_reg <= mad_pkg::RST_BYTE;
      done_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      done_reg  <= last_data;
      if (last_data && cyc.rd)
        rdata_reg <= cyc.pin_c;
    end
  end

  // Status toward the port logic
  assign cyc.busy    = (state_reg != mad_pkg::CYC_IDLE);
  assign cyc.done    = done_reg;
  assign cyc.rdata   = rdata_reg;
  assign cyc.e_clk   = (state_reg == mad_pkg::CYC_DATA);
  assign cyc.data_ph = (state_reg == mad_pkg::CYC_DATA);
  assign cyc.as_hi   = (state_reg == mad_pkg::CYC_ADDR)
                       && (cnt_reg < AS_CNT);

endmodule : mad_ecycle

// ===== tb/mad_port_monitor.sv
// Assertion checker for the multiplexed port pins
`timescale 1ns/100ps
module mad_port_monitor (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Pins
  input wire logic [7:0] output_port_bit,
  input wire logic [7:0] bidir_port_bit_oe,
  input wire logic       address_latch_strobe_out,
  input wire logic       address_latch_strobe_oe,
  input wire logic       output_strobe_pin,
  input wire logic       e_clk,
  input wire logic       irq
);
  // Short aliases
  wire       as_o = address_latch_strobe_out;
  wire       as_e = address_latch_strobe_oe;
  wire       rw   = output_strobe_pin;
  wire [7:0] oe   = bidir_port_bit_oe;

  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_mode; !as_e |-> !as_o && !e_clk; endproperty
  property p_as_len; $rose(as_o) |-> as_o[*5] ##1 !as_o; endproperty
  property p_addr; as_o |-> oe == 8'hff; endproperty
  property p_gap; $fell(as_o) |-> !e_clk[*7] ##1 e_clk; endproperty
  property p_data; $rose(e_clk) |-> e_clk[*8]; endproperty
  property p_rd; e_clk && rw |-> oe == 8'h00; endproperty
  property p_wr; e_clk && !rw |-> oe == 8'hff; endproperty
  property p_hi;
    e_clk |-> $stable(output_port_bit) && $stable(rw);
  endproperty

  a_mode: assert property (p_mode)
    else $error("bus strobe or E active in single-chip");
  a_as_len: assert property (p_as_len)
    else $error("address strobe width wrong");
  a_addr: assert property (p_addr)
    else $error("low address not driven");
  a_gap: assert property (p_gap)
    else $error("address half length wrong");
  a_data: assert property (p_data)
    else $error("data half too short");
  a_rd: assert property (p_rd)
    else $error("port driven in read data half");
  a_wr: assert property (p_wr)
    else $error("write data not driven");
  a_hi: assert property (p_hi)
    else $error("high address or direction moved");

  // Main scenarios seen
  c_wr: cover property ($rose(e_clk) && !rw);
  c_rd: cover property ($rose(e_clk) && rw);
  c_irq: cover property ($rose(irq));
endmodule : mad_port_monitor

bind mad_port mad_port_monitor u_mon (
  .clk                      (clk),
  .rst_n                    (rst_n),
  .output_port_bit          (output_port_bit),
  .bidir_port_bit_oe        (bidir_port_bit_oe),
  .address_latch_strobe_out (address_latch_strobe_out),
  .address_latch_strobe_oe  (address_latch_strobe_oe),
  .output_strobe_pin        (output_strobe_pin),
  .e_clk                    (e_clk),
  .irq                      (irq)
);

// ===== tb/mad_ext_mem.sv
// Model of the external address latch and byte memory
`timescale 1ns/100ps
module mad_ext_mem #(
  parameter int RD_DLY = 3
) (
  // Clock
  input  wire logic       clk,
  // Bus pins
  input  wire logic       ale,
  input  wire logic       rw,
  input  wire logic       e_clk,
  input  wire logic [7:0] addr_hi,
  input  wire logic [7:0] pin,
  output logic      [7:0] drv_d,
  output logic            drv_oe
);
  logic [7:0]  mem_q [0:65535];
  logic [15:0] lat_q;
  logic [7:0]  wd_q;
  logic [7:0]  fill_q = 8'h55;
  logic        e_q    = 1'b0;
  int          cnt_q  = 0;

  // Read data only while E high, late by a few cycles
  assign drv_oe = e_clk && rw && (cnt_q >= RD_DLY);
  assign drv_d  = drv_oe ? mem_q[lat_q] : fill_q;

  // Latch, write capture and changing filler on a released bus
  always @(posedge clk)
  begin
    if (ale)
      lat_q <= {addr_hi, pin};
    if (e_clk && !rw)
      wd_q <= pin;
    if (e_q && !e_clk && !rw)
      mem_q[lat_q] <= wd_q;
    cnt_q  <= e_clk ? cnt_q + 1 : 0;
    e_q    <= e_clk;
    fill_q <= ~fill_q;
  end
endmodule : mad_ext_mem

// ===== tb/testbench.sv
// Self-checking bench for the multiplexed port block
`timescale 1ns/100ps
module testbench;
  logic        clk, rst_n, hsel, hwrite, hreadyout, hresp, stb;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [7:0]  pb, c_out, c_oe, tb_pin, ext_d, pin_c;
  logic        as_o, as_e, rw, e_clk, irq, ext_oe;
  int          mismatches = 0;
  int          compares = 0;

  // ----------
  // Clock, wire and parts
  // ----------
  always #10 clk = ~clk;
  assign pin_c = (c_oe & c_out) | (~c_oe & (as_e ? ext_d : tb_pin));

  mad_port dut (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .output_port_bit(pb),
    .bidir_port_bit_in(pin_c), .bidir_port_bit_out(c_out),
    .bidir_port_bit_oe(c_oe), .input_strobe_pin_in(stb),
    .address_latch_strobe_out(as_o),
    .address_latch_strobe_oe(as_e), .output_strobe_pin(rw),
    .e_clk(e_clk), .irq(irq));

  mad_ext_mem u_mem (
    .clk(clk), .ale(as_o), .rw(rw), .e_clk(e_clk), .addr_hi(pb),
    .pin(pin_c), .drv_d(ext_d), .drv_oe(ext_oe));

  // ----------
  // Bus and compare tasks
  // ----------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // Wait for hready high at a rising edge; the watchdog ends a hang
  task automatic rdy;
    @(posedge clk);
    while (hreadyout !== 1'b1)
      @(posedge clk);
  endtask : rdy

  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    rdy;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    q = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    ahb(1'b0, a, 32'h0);
  endtask : rd

  task automatic chk_y(input logic [7:0] a, input logic [7:0] e);
    compares++;
    if (a !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h want %h", $time, a, e);
    end
  endtask : chk_y

  task automatic chk_b(input logic a, input logic e);
    chk_y({7'h0, a}, {7'h0, e});
  endtask : chk_b

  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  // ----------
  // Scenarios
  // ----------
  task automatic t_reset;
    chk_b(as_e, 1'b0);
    chk_b(hresp, 1'b0);
    chk_y(pb, 8'h00);
    chk_y(c_oe, 8'h00);
    rd(8'h3c);
    chk_y(q[7:0], 8'h00);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_ports;
    wr(8'h04, 32'ha5);
    wr(8'h0c, 32'h0f);
    wr(8'h08, 32'h3c);
    wr(8'h00, 32'h4);
    tb_pin <= 8'h90;
    cyc(4);
    chk_y(pb, 8'ha5);
    chk_y(c_oe, 8'h0f);
    chk_y(c_out & 8'h0f, 8'h0c);
    chk_b(rw, 1'b1);
    rd(8'h08);
    chk_y(q[7:0], 8'h9c);
    wr(8'h00, 32'h0);
    cyc(2);
    chk_b(rw, 1'b0);
    $display("t_ports done");
  endtask : t_ports

  task automatic t_strobe;
    logic [7:0] v, e;
    wr(8'h18, 32'h1);
    for (int p = 0; p < 2; p++)
    begin
      v = p ? 8'hc3 : 8'h5a;
      // Low nibble still driven as outputs with port C data
      e = (v & 8'hf0) | 8'h0c;
      wr(8'h00, p * 2);
      stb <= ~p[0];
      cyc(6);
      wr(8'h14, 32'h1);
      tb_pin <= v;
      cyc(4);
      stb <= p[0];
      cyc(6);
      chk_b(irq, 1'b1);
      rd(8'h14);
      chk_y(q[7:0], 8'h01);
      rd(8'h10);
      chk_y(q[7:0], e);
      tb_pin <= ~v;
      stb <= ~p[0];
      cyc(6);
      rd(8'h10);
      chk_y(q[7:0], e);
      wr(8'h14, 32'h1);
      cyc(2);
      chk_b(irq, 1'b0);
    end
    $display("t_strobe done");
  endtask : t_strobe

  // Poll busy, then let the far side finish its write
  task automatic idle;
    cyc(4);
    rd(8'h14);
    while (q[2] !== 1'b0)
      rd(8'h14);
    cyc(2);
  endtask : idle

  task automatic xfer(input logic [15:0] a, input logic [7:0] d);
    wr(8'h1c, a);
    wr(8'h20, d);
    cyc(3);
    chk_y(pb, a[15:8]);
    wr(8'h24, 32'h0);
    cyc(4);
    chk_b(rw, 1'b0);
    idle;
    chk_y(u_mem.mem_q[a], d);
    chk_b(irq, 1'b1);
    wr(8'h14, 32'h2);
    wr(8'h20, 32'h0);
    wr(8'h24, 32'h1);
    idle;
    chk_b(rw, 1'b1);
    rd(8'h20);
    chk_y(q[7:0], d);
    wr(8'h14, 32'h2);
  endtask : xfer

  task automatic t_expand;
    wr(8'h18, 32'h2);
    wr(8'h00, 32'h1);
    cyc(3);
    chk_b(as_e, 1'b1);
    xfer(16'hc35a, 8'h6b);
    xfer(16'hffff, 8'ha5);
    $display("t_expand done");
  endtask : t_expand

  // ----------
  // Main sequence and watchdog
  // ----------
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    tb_pin = 8'h00;
    stb = 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(3);
    t_reset;
    t_ports;
    t_strobe;
    t_expand;
    test_done;
  end

  initial
  begin
    #400000;
    mismatches++;
    test_done;
  end
endmodule : testbench
